// file: src/plc_mode_pkg.sv
package plc_mode_pkg;
// Operation
// - Breakpoint reached in run enters hold
// - At most three breakpoints defined
// - Single step refused above two breakpoints
// - Hold blinks run, stop indicator steady
// - Hold halts execution and freezes timers
// - Real-time clock keeps counting in hold
// - Hold asserts output lock
// - 100 ms watchdog forces defined stop
// - Cycle limit, minimum 1 ms, forces stop
// - Run to stop asserts output lock
// - Locked analog outputs go safe or substitute
// - Start-up sequence then release lock, cycle
// - Scan order: read, cyclic, write
// - Memory reset erases user memory only
// - Three second hold arms memory reset
// - Quick stop-reset-stop gesture starts reset
// - Steady stop indicator when reset done
// - Card reload lights card indicator, then mode
// - Factory reset restores bus address 2
// - Power-on stop checks differing card firmware
// - Stop and run indicator patterns
// - Start-up run blink lasts three seconds
  localparam int CLK_NS     = 25;
  localparam int MS_NS      = 1_000_000;
  localparam int MS_CYCLES  = MS_NS / CLK_NS;
  localparam int S_TO_MS    = 1000;
  localparam int WD_MS      = 100;
  localparam int CYC_MIN_MS = 1;
  localparam int MEMORY_RESET_POSITION_S     = 3;
  localparam int SU_BLINK_S = 3;
  localparam int MEMORY_RESET_POSITION_MS    = MEMORY_RESET_POSITION_S * S_TO_MS;
  localparam int SU_MS      = SU_BLINK_S * S_TO_MS;
  localparam int DEB_MS     = 10;
  localparam int BLINK_MS   = 250;
  localparam int BP_MAX     = 3;
  localparam int BP_STEP_MAX = 2;
  localparam logic [6:0]  MPI_DEF = 7'h02;
  localparam logic [15:0] CYC_DEF = 16'h0096;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_BP   = 8'h08;
  localparam logic [7:0] A_CYC  = 8'h0C;
  localparam logic [7:0] A_MPI  = 8'h10;
  localparam logic [7:0] A_ACFG = 8'h14;
  localparam logic [7:0] A_ASUB = 8'h18;
  localparam logic [7:0] A_RTC  = 8'h1C;
  localparam int CB_STEP   = 0;
  localparam int CB_RESUME = 1;
  localparam int CB_KICK   = 2;
  localparam int CB_FACT   = 3;
  localparam int CB_UPD    = 4;
  localparam int CB_FCLR   = 5;
  localparam int AC_SUB    = 2;
  localparam logic [1:0] RNG_V    = 2'h0;
  localparam logic [1:0] RNG_0_20 = 2'h1;
  localparam logic [1:0] RNG_4_20 = 2'h2;
  typedef enum logic [3:0] {S_INIT, S_STOP, S_START, S_RUN, S_HOLD, S_MEMORY_RESET_POSITION, S_RELOAD, S_FACT, S_FWWAIT} state_t;
  typedef enum logic [3:0] {C_NONE, C_CLR_IN, C_STARTUP, C_CLR_OUT, C_READ_IN, C_CYCLIC, C_WRITE_OUT, C_ERASE,
                            C_RELOAD, C_FACTORY} cmd_t;
endpackage

// file: src/switch_filter.sv
module switch_filter
  import plc_mode_pkg::*;
#(
  parameter int W = 2,
  parameter int N = DEB_MS
)(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  // Timing and pins
  input  wire logic         ms_tick,
  input  wire logic [W-1:0] raw,
  // Filtered levels
  output logic      [W-1:0] clean,
  output logic              settled
);
  logic [W-1:0] done;

  assign settled = &done;

  generate
    for (genvar i = 0; i < W; i++)
    begin : g_bit
      logic       meta;
      logic       sync;
      logic       prev;
      logic [7:0] cnt;
      // Accept a level once stable for N ticks
      always_ff @(posedge clk_sys or negedge reset_n)
      begin
        if (!reset_n)
        begin
          meta     <= 1'b0;
          sync     <= 1'b0;
          prev     <= 1'b0;
          cnt      <= 8'h00;
          clean[i] <= 1'b0;
          done[i]  <= 1'b0;
        end
        else
        begin
          meta <= raw[i];
          sync <= meta;
          prev <= sync;
          if (sync != prev)
            cnt <= 8'h00;
          else if (cnt == 8'(N))
          begin
            clean[i] <= prev;
            done[i]  <= 1'b1;
          end
          else if (ms_tick)
            cnt <= cnt + 8'h01;
        end
      end
    end
  endgenerate
endmodule

// file: src/cycle_supervisor.sv
module cycle_supervisor #(
  parameter int W = 16
)(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  // Control
  input  wire logic         ms_tick,
  input  wire logic         enable,
  input  wire logic         restart,
  input  wire logic [W-1:0] limit,
  // Timeout level
  output logic              expired
);
  logic [W-1:0] cnt;

  assign expired = enable && (cnt >= limit);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      cnt <= '0;
    else if (!enable || restart)
      cnt <= '0;
    else if (ms_tick && !expired)
      cnt <= cnt + W'(1);
  end
endmodule

// file: src/plc_mode_ctrl.sv
module plc_mode_ctrl
  import plc_mode_pkg::*;
#(
  parameter int          MS_CYC  = MS_CYCLES,
  parameter int          DW      = 16,
  parameter logic [15:0] AO_ZERO = 16'h0000,
  parameter logic [15:0] AO_4MA  = 16'h3333
)(
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          reset_n,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  // Mode switch pins
  input  wire logic          sw_run_pin,
  input  wire logic          sw_memory_reset_position_pin,
  // Indicators
  output logic               run_indicator,
  output logic               stop_indicator,
  output logic               card_indicator,
  // Execution core
  output cmd_t               core_cmd,
  input  wire logic          core_done,
  input  wire logic          bp_hit,
  output logic               exec_halt,
  output logic               timer_freeze,
  output logic               step_pulse,
  output logic               wd_reset,
  // Memory card
  input  wire logic          card_project,
  input  wire logic          card_fw_present,
  input  wire logic [15:0]   card_fw_ver,
  input  wire logic [15:0]   fw_ver,
  output logic               fw_update_start,
  output logic      [6:0]    mpi_addr,
  // Process outputs
  output logic               output_lock,
  input  wire logic [DW-1:0] output_image,
  output logic      [DW-1:0] dig_out,
  input  wire logic [15:0]   ana_image,
  output logic      [15:0]   ana_out
);
  state_t      state, next_state;
  cmd_t        cmd, next_cmd;
  logic [15:0] tick_cnt;
  logic        ms_tick;
  logic [8:0]  blink_cnt;
  logic        blink;
  logic [1:0]  sw;
  logic        sw_ok, sw_run, sw_memory_reset_position, memory_reset_position_q, run_q;
  logic [11:0] memory_reset_position_ms, su_ms;
  logic        armed, armed_rdy;
  logic        wd_exp, cyc_exp, wd_fault, cyc_fault;
  logic [1:0]  bp_cnt;
  logic [15:0] cyc_lim, asub;
  logic [2:0]  acfg;
  logic [31:0] rtc_ms, rd_val;
  logic        wr_pend;
  logic [7:0]  wa;

  // Bus decode
  wire ap        = hsel && htrans[1] && hready;
  wire hi_zero   = ~|haddr[31:8];
  wire wr_ctrl   = wr_pend && wa == A_CTRL;
  wire step_req  = wr_ctrl && hwdata[CB_STEP];
  wire resume    = wr_ctrl && hwdata[CB_RESUME];
  wire wd_kick   = wr_ctrl && hwdata[CB_KICK];
  wire fact_req  = wr_ctrl && hwdata[CB_FACT];
  wire upd_req   = wr_ctrl && hwdata[CB_UPD];
  wire flt_clr   = wr_ctrl && hwdata[CB_FCLR];
  wire in_stop   = state == S_STOP;
  wire run_rise  = sw_run && !run_q;
  wire memory_reset_position_fall = memory_reset_position_q && !sw_memory_reset_position;
  wire memory_reset_position_go   = armed_rdy && memory_reset_position_fall && memory_reset_position_ms < 12'(MEMORY_RESET_POSITION_MS);
  wire fw_new    = card_fw_present && card_fw_ver != fw_ver;
  wire cyc_end   = state == S_RUN && cmd == C_WRITE_OUT && core_done;
  wire step_ok   = bp_cnt <= 2'(BP_STEP_MAX);
  wire lock_w    = state != S_RUN;
  wire su_blink  = su_ms != 12'h000;
  assign sw_run  = sw[0];
  assign sw_memory_reset_position = sw[1];

  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign core_cmd     = cmd;
  assign exec_halt    = state == S_HOLD;
  assign timer_freeze = state == S_HOLD;

  // Safe analog value while locked
  function automatic logic [15:0] safe_code(input logic [2:0] cfg, input logic [15:0] sub);
    if (cfg[AC_SUB])
      safe_code = sub;
    else if (cfg[1:0] == RNG_4_20)
      safe_code = AO_4MA;
    else
      safe_code = AO_ZERO;
  endfunction

  switch_filter #(.W(2), .N(DEB_MS)) u_filter (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .ms_tick (ms_tick),
    .raw     ({sw_memory_reset_position_pin, sw_run_pin}),
    .clean   (sw),
    .settled (sw_ok)
  );

  cycle_supervisor #(.W(16)) u_wd (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .ms_tick (ms_tick),
    .enable  (state == S_RUN),
    .restart (wd_kick),
    .limit   (16'(WD_MS)),
    .expired (wd_exp)
  );

  cycle_supervisor #(.W(16)) u_cyc (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .ms_tick (ms_tick),
    .enable  (state == S_RUN),
    .restart (cyc_end),
    .limit   (cyc_lim),
    .expired (cyc_exp)
  );

  // Mode sequencing
  always_comb
  begin
    next_state = state;
    next_cmd   = cmd;
    case (state)
      S_INIT:
        if (sw_ok)
        begin
          if (sw_run)
          begin
            next_state = S_START;
            next_cmd   = C_CLR_IN;
          end
          else
            next_state = fw_new ? S_FWWAIT : S_STOP;
        end
      S_STOP:
        if (memory_reset_position_go)
        begin
          next_state = S_MEMORY_RESET_POSITION;
          next_cmd   = C_ERASE;
        end
        else if (fact_req)
        begin
          next_state = S_FACT;
          next_cmd   = C_FACTORY;
        end
        else if (run_rise)
        begin
          next_state = S_START;
          next_cmd   = C_CLR_IN;
        end
      S_START:
        if (!sw_run)
        begin
          next_state = S_STOP;
          next_cmd   = C_NONE;
        end
        else if (core_done && cmd == C_CLR_IN)
          next_cmd = C_STARTUP;
        else if (core_done)
        begin
          next_state = S_RUN;
          next_cmd   = C_CLR_OUT;
        end
      S_RUN:
        if (!sw_run || wd_exp || cyc_exp)
        begin
          next_state = S_STOP;
          next_cmd   = C_NONE;
        end
        else if (bp_hit)
          next_state = S_HOLD;
        else if (core_done)
          next_cmd = (cmd == C_READ_IN) ? C_CYCLIC : (cmd == C_CYCLIC) ? C_WRITE_OUT : C_READ_IN;
      S_HOLD:
        if (!sw_run)
        begin
          next_state = S_STOP;
          next_cmd   = C_NONE;
        end
        else if (resume)
          next_state = S_RUN;
      S_MEMORY_RESET_POSITION:
        if (core_done && card_project)
        begin
          next_state = S_RELOAD;
          next_cmd   = C_RELOAD;
        end
        else if (core_done)
        begin
          next_state = S_STOP;
          next_cmd   = C_NONE;
        end
      S_RELOAD:
        if (core_done)
        begin
          next_state = sw_run ? S_START : S_STOP;
          next_cmd   = sw_run ? C_CLR_IN : C_NONE;
        end
      S_FACT:
        if (core_done)
        begin
          next_state = S_STOP;
          next_cmd   = C_NONE;
        end
      S_FWWAIT:
        if (upd_req)
          next_state = S_STOP;
        else if (run_rise)
        begin
          next_state = S_START;
          next_cmd   = C_CLR_IN;
        end
      default:
      begin
        next_state = S_INIT;
        next_cmd   = C_NONE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= S_INIT;
      cmd   <= C_NONE;
    end
    else
    begin
      state <= next_state;
      cmd   <= next_cmd;
    end
  end

  // Millisecond tick, blink and real-time clock
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tick_cnt  <= 16'h0000;
      ms_tick   <= 1'b0;
      blink_cnt <= 9'h000;
      blink     <= 1'b0;
      rtc_ms    <= 32'h0000_0000;
    end
    else
    begin
      ms_tick  <= tick_cnt == 16'(MS_CYC - 1);
      tick_cnt <= (tick_cnt == 16'(MS_CYC - 1)) ? 16'h0000 : tick_cnt + 16'h0001;
      if (ms_tick)
      begin
        rtc_ms    <= rtc_ms + 32'h0000_0001;
        blink_cnt <= (blink_cnt == 9'(BLINK_MS - 1)) ? 9'h000 : blink_cnt + 9'h001;
        blink     <= (blink_cnt == 9'(BLINK_MS - 1)) ? !blink : blink;
      end
    end
  end

  // Memory-reset gesture and start-up blink
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      memory_reset_position_q    <= 1'b0;
      run_q     <= 1'b0;
      memory_reset_position_ms   <= 12'h000;
      armed     <= 1'b0;
      armed_rdy <= 1'b0;
      su_ms     <= 12'h000;
    end
    else
    begin
      memory_reset_position_q <= sw_memory_reset_position;
      run_q  <= sw_run;
      if (!sw_memory_reset_position || !in_stop)
        memory_reset_position_ms <= 12'h000;
      else if (ms_tick && memory_reset_position_ms != 12'(MEMORY_RESET_POSITION_MS))
        memory_reset_position_ms <= memory_reset_position_ms + 12'h001;
      armed     <= in_stop && (armed || memory_reset_position_ms == 12'(MEMORY_RESET_POSITION_MS));
      armed_rdy <= in_stop && armed && (armed_rdy || !sw_memory_reset_position);
      if (next_state == S_START && state != S_START)
        su_ms <= 12'(SU_MS);
      else if (ms_tick && su_blink)
        su_ms <= su_ms - 12'h001;
    end
  end

  // Indicators, strobes and gated outputs
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      run_indicator   <= 1'b0;
      stop_indicator  <= 1'b0;
      card_indicator  <= 1'b0;
      output_lock     <= 1'b1;
      dig_out         <= '0;
      ana_out         <= AO_ZERO;
      step_pulse      <= 1'b0;
      wd_reset        <= 1'b0;
      fw_update_start <= 1'b0;
    end
    else
    begin
      run_indicator <= su_blink || state == S_HOLD || state == S_FWWAIT ? blink : state == S_RUN;
      case (state)
        S_STOP:   stop_indicator <= armed ? blink : 1'b1;
        S_HOLD:   stop_indicator <= 1'b1;
        S_MEMORY_RESET_POSITION, S_RELOAD, S_FACT, S_FWWAIT:
                  stop_indicator <= blink;
        default:  stop_indicator <= 1'b0;
      endcase
      card_indicator  <= state == S_RELOAD;
      output_lock     <= lock_w;
      dig_out         <= lock_w ? '0 : output_image;
      ana_out         <= lock_w ? safe_code(acfg, asub) : ana_image;
      step_pulse      <= state == S_HOLD && step_req && step_ok;
      wd_reset        <= state == S_RUN && wd_exp;
      fw_update_start <= state == S_FWWAIT && upd_req;
    end
  end

  // Register file
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_pend   <= 1'b0;
      wa        <= 8'h00;
      hrdata    <= 32'h0000_0000;
      bp_cnt    <= 2'h0;
      cyc_lim   <= CYC_DEF;
      mpi_addr  <= MPI_DEF;
      acfg      <= 3'h0;
      asub      <= 16'h0000;
      wd_fault  <= 1'b0;
      cyc_fault <= 1'b0;
    end
    else
    begin
      wr_pend <= ap && hwrite && hi_zero;
      wa      <= haddr[7:0];
      if (ap && !hwrite)
        hrdata <= rd_val;
      if (wr_pend && wa == A_BP)
        bp_cnt <= |hwdata[31:2] ? 2'(BP_MAX) : hwdata[1:0];
      if (wr_pend && wa == A_CYC)
        cyc_lim <= hwdata[15:0] < 16'(CYC_MIN_MS) ? 16'(CYC_MIN_MS) : hwdata[15:0];
      if (in_stop && fact_req)
        mpi_addr <= MPI_DEF;
      else if (wr_pend && wa == A_MPI)
        mpi_addr <= hwdata[6:0];
      if (wr_pend && wa == A_ACFG)
        acfg <= hwdata[2:0];
      if (wr_pend && wa == A_ASUB)
        asub <= hwdata[15:0];
      wd_fault  <= (state == S_RUN && wd_exp) || (wd_fault && !flt_clr);
      cyc_fault <= (state == S_RUN && cyc_exp) || (cyc_fault && !flt_clr);
    end
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (hi_zero)
      case (haddr[7:0])
        A_STAT: rd_val = {21'h0, step_ok, cyc_fault, wd_fault, armed, output_lock, sw_memory_reset_position, sw_run, state};
        A_BP:   rd_val = {30'h0, bp_cnt};
        A_CYC:  rd_val = {16'h0, cyc_lim};
        A_MPI:  rd_val = {25'h0, mpi_addr};
        A_ACFG: rd_val = {29'h0, acfg};
        A_ASUB: rd_val = {16'h0, asub};
        A_RTC:  rd_val = rtc_ms;
        default: rd_val = 32'h0000_0000;
      endcase
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  hold_enter_a: assert property (
    state == S_RUN && bp_hit && sw_run && !wd_exp && !cyc_exp |=> state == S_HOLD)
    else $error("breakpoint did not enter hold");
  step_gate_a: assert property (
    step_pulse |-> $past(state) == S_HOLD && $past(bp_cnt) <= 2'(BP_STEP_MAX))
    else $error("single step not refused");
  hold_led_a: assert property (
    state == S_HOLD && !su_blink |=> stop_indicator && run_indicator == $past(blink))
    else $error("hold indicator pattern wrong");
  rtc_count_a: assert property (
    ms_tick |=> rtc_ms == $past(rtc_ms) + 32'h0000_0001)
    else $error("real-time clock stalled");
  hold_lock_a: assert property (
    state == S_HOLD |=> output_lock && dig_out == '0)
    else $error("outputs live in hold");
  wd_stop_a: assert property (
    state == S_RUN && wd_exp |=> state == S_STOP && wd_fault && wd_reset)
    else $error("watchdog did not stop");
  cyc_stop_a: assert property (
    state == S_RUN && cyc_exp |=> state == S_STOP && cyc_fault)
    else $error("cycle overrun did not stop");
  stop_lock_a: assert property (
    state == S_RUN && !sw_run |=> ##1 output_lock && dig_out == '0)
    else $error("run to stop left outputs on");
  ana_safe_a: assert property (
    lock_w && !acfg[AC_SUB] && acfg[1:0] == RNG_4_20 |=> ana_out == AO_4MA)
    else $error("analog safe value wrong");
  startup_seq_a: assert property (
    state == S_START && cmd == C_STARTUP && core_done && sw_run |=> state == S_RUN && cmd == C_CLR_OUT && !lock_w)
    else $error("start-up sequence wrong");
  scan_order_a: assert property (
    state == S_RUN && cmd == C_CYCLIC && core_done && next_state == S_RUN |=> cmd == C_WRITE_OUT)
    else $error("scan order broken");
  memory_reset_position_start_a: assert property (
    memory_reset_position_go |=> state == S_MEMORY_RESET_POSITION && cmd == C_ERASE)
    else $error("memory reset not started");
  su_blink_a: assert property (
    state == S_START && $past(state) != S_START |-> su_ms == 12'(SU_MS))
    else $error("start-up blink not loaded");

  hold_seen_c: cover property (state == S_RUN ##1 state == S_HOLD);
  memory_reset_position_seen_c: cover property (state == S_MEMORY_RESET_POSITION ##1 state == S_RELOAD);
  run_seen_c: cover property (state == S_START ##1 state == S_RUN);
endmodule

// file: tb/core_model.sv
module core_model
  import plc_mode_pkg::*;
(
  // Clock
  input  wire logic       clk_sys,
  // Core link
  input  cmd_t            core_cmd,
  input  wire logic [7:0] lat,
  output logic            core_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int   cnt = 0;
  cmd_t last = C_NONE;
  initial core_done = 1'b0;
  // One done pulse per command for lat of 1 or more, lat + 1 cycles after it shows; none when lat is 0
  always @(posedge clk_sys)
  begin
    last <= core_cmd;
    core_done <= (core_cmd == last && core_cmd != C_NONE && cnt == int'(lat));
    if (core_cmd != last)
      cnt <= 1;
    else if (cnt <= int'(lat))
      cnt <= cnt + 1;
  end
endmodule

// file: tb/plc_operating_mode_controller_tb_top.sv
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module plc_operating_mode_controller_tb_top import plc_mode_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MSC = 8;
  localparam logic [15:0] AZ = 16'h0000;
  localparam logic [15:0] A4 = 16'h3333;
  logic        clk_sys = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, a;
  logic        hreadyout, hresp, sw_run_pin = 1'b0, sw_memory_reset_position_pin = 1'b0, bp_hit = 1'b0;
  logic        run_indicator, stop_indicator, card_indicator, exec_halt, timer_freeze;
  logic        step_pulse, wd_reset, fw_update_start, output_lock, core_done, run_q, stop_q;
  logic        card_project = 1'b0, card_fw_present = 1'b0;
  logic [15:0] card_fw_ver = 16'h0001, fw_ver = 16'h0001, output_image, dig_out, ana_image, ana_out, rnd;
  logic [6:0]  mpi_addr;
  logic [7:0]  lat = 8'd2;
  logic [2:0]  cfg [4] = '{3'h0, 3'h1, 3'h2, 3'h6};
  cmd_t        core_cmd;
  cmd_t        seen [$];
  cmd_t        exp_q [$] = '{C_CLR_IN, C_STARTUP, C_CLR_OUT, C_READ_IN, C_CYCLIC, C_WRITE_OUT, C_READ_IN};
  int          err_count = 0, check_count = 0, run_tg = 0, stop_tg = 0, steps = 0, wds = 0, fws = 0;

  assign hready = hreadyout;

  plc_mode_ctrl #(.MS_CYC(MSC), .DW(16), .AO_ZERO(AZ), .AO_4MA(A4)) plc_mode_ctrl_inst (
    .clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .sw_run_pin, .sw_memory_reset_position_pin, .run_indicator, .stop_indicator, .card_indicator,
    .core_cmd, .core_done, .bp_hit, .exec_halt, .timer_freeze, .step_pulse, .wd_reset,
    .card_project, .card_fw_present, .card_fw_ver, .fw_ver, .fw_update_start, .mpi_addr,
    .output_lock, .output_image, .dig_out, .ana_image, .ana_out
  );

  core_model core_model_inst (.clk_sys, .core_cmd, .lat, .core_done);

  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Indicator edges and one-cycle pulses seen by the bench model
  always @(posedge clk_sys)
  begin
    run_tg += int'(run_indicator !== run_q);
    stop_tg += int'(stop_indicator !== stop_q);
    run_q = run_indicator;
    stop_q = stop_indicator;
    steps += int'(step_pulse === 1'b1);
    wds += int'(wd_reset === 1'b1);
    fws += int'(fw_update_start === 1'b1);
  end

  always @(core_cmd)
    if (core_cmd != C_NONE)
      seen.push_back(core_cmd);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, {24'h0, ad}, d, r);
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] r);
    bus(1'b0, {24'h0, ad}, 32'h0, r);
  endtask

  // Whole milliseconds, servicing the watchdog unless told not to
  task automatic wait_ms(input int n, input bit kick = 1'b1);
    repeat (n)
    begin
      if (kick)
        wr(A_CTRL, 32'h1 << CB_KICK);
      repeat (kick ? MSC - 2 : MSC) @(posedge clk_sys);
    end
  endtask

  task automatic st(input state_t s);
    rd(A_STAT, q);
    `CHK(q[3:0], 4'(s))
  endtask

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    rnd = lfsr(16'h0018);
    output_image <= rnd;
    ana_image <= lfsr(rnd);
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    `CHK({output_lock, mpi_addr}, {1'b1, MPI_DEF})
    wait_ms(15);
    st(S_STOP);
    `CHK({run_indicator, stop_indicator}, 2'h1)
    wr(A_CYC, 32'h0);
    rd(A_CYC, q);
    `CHK(q, 32'h1)
    wr(A_BP, 32'h7);
    rd(A_BP, q);
    `CHK(q, 32'h3)
    bus(1'b0, 32'h100, 32'h0, q);
    `CHK(q, 32'h0)
    wr(A_CYC, 32'h96);
    wr(A_ASUB, 32'h1234);
    foreach (cfg[i])
    begin
      wr(A_ACFG, 32'(cfg[i]));
      repeat (2) @(posedge clk_sys);
      `CHK(ana_out, cfg[i][2] ? 16'h1234 : (cfg[i][1:0] == RNG_4_20 ? A4 : AZ))
    end
    `CHK(dig_out, 16'h0)
    tdone("stop");
    seen.delete();
    run_tg = 0;
    sw_run_pin <= 1'b1;
    wait_ms(600);
    st(S_RUN);
    `CHK(run_tg >= 2, 1'b1)
    `CHK({output_lock, dig_out, ana_out, hresp}, {1'b0, output_image, ana_image, 1'b0})
    foreach (exp_q[i])
      `CHK(seen[i], exp_q[i])
    wait_ms(2700);
    run_tg = 0;
    wait_ms(20);
    `CHK(run_tg == 0 && run_indicator === 1'b1 && stop_indicator === 1'b0, 1'b1)
    tdone("start");
    wr(A_BP, 32'h3);
    bp_hit <= 1'b1;
    @(posedge clk_sys);
    bp_hit <= 1'b0;
    repeat (3) @(posedge clk_sys);
    st(S_HOLD);
    `CHK({exec_halt, timer_freeze, output_lock, stop_indicator}, 4'hF)
    rd(A_RTC, a);
    wait_ms(5);
    rd(A_RTC, q);
    `CHK((q - a) inside {32'd5, 32'd6}, 1'b1)
    steps = 0;
    wr(A_CTRL, 32'h1);
    wr(A_BP, 32'h2);
    wr(A_CTRL, 32'h1);
    repeat (2) @(posedge clk_sys);
    `CHK(steps, 1)
    run_tg = 0;
    wait_ms(600);
    `CHK(run_tg >= 2 && stop_indicator === 1'b1, 1'b1)
    wr(A_CTRL, 32'h2);
    repeat (2) @(posedge clk_sys);
    st(S_RUN);
    tdone("hold");
    lat <= 8'd80;
    wr(A_CYC, 32'h1);
    wait_ms(20);
    st(S_STOP);
    `CHK({q[9], output_lock, dig_out}, {2'h3, 16'h0})
    lat <= 8'd2;
    wr(A_CYC, 32'h96);
    wr(A_CTRL, 32'h20);
    // Second pass leaves run by the switch
    repeat (2)
    begin
      sw_run_pin <= 1'b0;
      wait_ms(20);
      st(S_STOP);
      `CHK({output_lock, dig_out}, {1'b1, 16'h0})
      sw_run_pin <= 1'b1;
      wait_ms(30);
      st(S_RUN);
    end
    wds = 0;
    wait_ms(110, 1'b0);
    st(S_STOP);
    `CHK(q[8] === 1'b1 && wds == 1, 1'b1)
    tdone("supervisors");
    sw_run_pin <= 1'b0;
    card_project <= 1'b1;
    wait_ms(20);
    sw_memory_reset_position_pin <= 1'b1;
    wait_ms(3050);
    rd(A_STAT, q);
    `CHK(q[7], 1'b1)
    stop_tg = 0;
    wait_ms(600);
    `CHK(stop_tg >= 2, 1'b1)
    sw_memory_reset_position_pin <= 1'b0;
    wait_ms(50);
    lat <= 8'd200;
    sw_memory_reset_position_pin <= 1'b1;
    wait_ms(100);
    sw_memory_reset_position_pin <= 1'b0;
    wait_ms(15);
    st(S_MEMORY_RESET_POSITION);
    `CHK(core_cmd, C_ERASE)
    wait_ms(25);
    st(S_RELOAD);
    `CHK(card_indicator, 1'b1)
    wait_ms(30);
    st(S_STOP);
    `CHK({card_indicator, stop_indicator}, 2'h1)
    tdone("memory reset");
    lat <= 8'd2;
    wr(A_MPI, 32'h5);
    rd(A_MPI, q);
    `CHK(q, 32'h5)
    wr(A_CTRL, 32'h8);
    wait_ms(2);
    `CHK(mpi_addr, 7'h02)
    card_fw_present <= 1'b1;
    card_fw_ver <= 16'h0002;
    reset_n <= 1'b0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    wait_ms(15);
    st(S_FWWAIT);
    fws = 0;
    wr(A_CTRL, 32'h10);
    repeat (2) @(posedge clk_sys);
    `CHK(fws, 1)
    tdone("factory and firmware");
    wrap_up();
  end

  initial
  begin
    repeat (90000) @(posedge clk_sys);
    err_count++;
    wrap_up();
  end
endmodule
